// [hdl/pcfg_cmd_decode.sv]
// pcfg_cmd_decode: sorts a bus command code into the target classes.
// assumes the code is the live c/be value, used only in an address phase.
`timescale 1ns/1ps

module pcfg_cmd_decode
   import pcfg_pkg::*;
(
   input wire logic [3:0] cmd,
   output logic is_cfg,
   output logic is_io,
   output logic is_mem,
   output logic is_write
);

   // ---------------------------------------------------------------
   // class decode
   // ---------------------------------------------------------------
   // unsupported and reserved codes fall in no class, so never claimed
   assign is_cfg = (cmd == PCFG_CMD_CFG_RD) || (cmd == PCFG_CMD_CFG_WR); // see R05
   assign is_io = (cmd == PCFG_CMD_IO_RD) || (cmd == PCFG_CMD_IO_WR); // see R05
   assign is_mem = (cmd == PCFG_CMD_MEM_RD) || (cmd == PCFG_CMD_MEM_WR); // see R04
   // low code bit tells write from read in all three classes
   assign is_write = cmd[0];

endmodule

// [hdl/pcfg_field_reg.sv]
// pcfg_field_reg: one 32-bit configuration register with byte lanes.
// assumes wr_en is a one-cycle strobe and set_bits are event pulses.
`timescale 1ns/1ps

module pcfg_field_reg
   import pcfg_pkg::*;
#(
   parameter logic [31:0] RST_VAL = 32'h0000_0000,
   parameter logic [31:0] WMASK = 32'h0000_0000,
   parameter logic [31:0] CMASK = 32'h0000_0000
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic core_ce,
   input wire logic wr_en,
   input wire logic [3:0] be_n,
   input wire logic [31:0] wdata,
   input wire logic [31:0] set_bits,
   output logic [31:0] q
);

   logic [31:0] lane_mask;
   logic [31:0] wr_bits;
   logic [31:0] reg_d;
   logic [31:0] reg_q;

   // ---------------------------------------------------------------
   // byte lane expansion
   // ---------------------------------------------------------------
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign lane_mask[8*b +: 8] = {8{~be_n[b]}}; // see R11
   end

   // ---------------------------------------------------------------
   // next value: plain writes, one-to-clear, hardware set wins
   // ---------------------------------------------------------------
   assign wr_bits = {32{wr_en}} & lane_mask;
   assign reg_d = (((reg_q & ~(wr_bits & WMASK)) | (wdata & wr_bits & WMASK))
                  & ~(wr_bits & wdata & CMASK)) | (set_bits & CMASK); // see R16

   // only the hardware reset touches this storage
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_q <= RST_VAL; // see R10
      end else if (core_ce) begin
         reg_q <= reg_d;
      end
   end

   assign q = reg_q;

endmodule

// [hdl/pcfg_pkg.sv]
// pcfg_pkg: shared constants and types for the pci configuration target.
// assumes a 32-bit multiplexed address/data bus sampled on core_clk.

package pcfg_pkg;

   // ---------------------------------------------------------------
   // bus command codes (c/be lines during the address phase)
   // ---------------------------------------------------------------
   localparam logic [3:0] PCFG_CMD_IO_RD = 4'h2;
   localparam logic [3:0] PCFG_CMD_IO_WR = 4'h3;
   localparam logic [3:0] PCFG_CMD_MEM_RD = 4'h6;
   localparam logic [3:0] PCFG_CMD_MEM_WR = 4'h7;
   localparam logic [3:0] PCFG_CMD_CFG_RD = 4'ha;
   localparam logic [3:0] PCFG_CMD_CFG_WR = 4'hb;

   // ---------------------------------------------------------------
   // configuration register offsets (byte addresses), in table order
   // ---------------------------------------------------------------
   localparam int PCFG_NREG = 10;
   localparam logic [7:0] PCFG_OFS [PCFG_NREG] = '{
      8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h2c, 8'h30, 8'h3c, 8'h40};
   localparam int PCFG_IDX_ID = 0;
   localparam int PCFG_IDX_CS = 1;
   localparam int PCFG_IDX_LT = 3;
   localparam int PCFG_IDX_IO = 4;
   localparam int PCFG_IDX_MEM = 5;
   localparam int PCFG_IDX_IT = 8;
   localparam int PCFG_IDX_DA = 9;

   // ---------------------------------------------------------------
   // writable bits, write-one-to-clear bits and values after reset
   // ---------------------------------------------------------------
   localparam logic [31:0] PCFG_WMASK [PCFG_NREG] = '{
      32'h0000_0000, 32'h0000_0147, 32'h0000_0000, 32'h0000_ff00, 32'hffff_ff80,
      32'hffff_ff80, 32'h0000_0000, 32'hffff_fc01, 32'h0000_00ff, 32'hffff_ffff};
   localparam logic [31:0] PCFG_CMASK_CS = 32'hf100_0000;
   localparam logic [31:0] PCFG_RST_CS = 32'h0280_0000;
   localparam logic [31:0] PCFG_RST_IO = 32'h0000_0001;
   localparam logic [31:0] PCFG_RST_IT = 32'h0000_0100;
   localparam logic [31:0] PCFG_RST_ZERO = 32'h0000_0000;

   // command bit positions and host register window
   localparam int PCFG_CMD_BIT_IO = 0;
   localparam int PCFG_CMD_BIT_MEM = 1;
   localparam int PCFG_CMD_BIT_MST = 2;
   localparam int PCFG_CMD_BIT_PER = 6;
   localparam int PCFG_CMD_BIT_SERR = 8;
   localparam int PCFG_WIN_LSB = 7;
   localparam int PCFG_CSR_LSB = 3;

   // ---------------------------------------------------------------
   // target sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      PCFG_ST_IDLE = 5'b00001,
      PCFG_ST_WAIT = 5'b00010,
      PCFG_ST_DATA = 5'b00100,
      PCFG_ST_STOP = 5'b01000,
      PCFG_ST_TURN = 5'b10000
   } pcfg_state_type;

endpackage

// [hdl/pcfg_target.sv]
// pcfg_target: pci target for configuration space and the host register
// window of the lan controller.
// assumes pci pins arrive synchronous to core_clk and that the pad ring
// resolves each pin from its output and output enable.
//
// Functional notes
// R01: data phase ends only with both ready
// R02: bus slave read ready means valid data
// R03: bus slave write ready means accepting data
// R04: memory read and write claimed as target
// R05: io and configuration commands only as target
// R06: unsupported and reserved commands never claimed
// R07: reserved configuration writes complete, data dropped
// R08: reserved configuration reads return zero
// R09: software reset leaves configuration registers alone
// R10: hardware reset restores configuration registers
// R11: byte, word, longword configuration access by lanes
// R12: ten registers decoded, gaps are reserved
// R13: identity holds device and maker codes, read only
// R14: sixteen host registers in io or memory
// R15: zero command stops all but configuration
// R16: status bits cleared by writing one
// R17: io and memory gated by command bits
// R18: configuration claimed only with idsel asserted
`timescale 1ns/1ps

module pcfg_target
   import pcfg_pkg::*;
#(
   parameter logic [15:0] DEVICE_CODE = 16'h0a5a, // arbitrary value
   parameter logic [15:0] MAKER_CODE = 16'h5a0a, // arbitrary value
   parameter logic [31:0] REVISION_VALUE = 32'h0200_0011, // arbitrary value
   parameter logic [31:0] SUBSYSTEM_VALUE = 32'h0000_0000 // arbitrary value
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic core_ce,
   input wire logic [31:0] ad_pins,
   output logic [31:0] ad_data,
   output logic ad_oe,
   input wire logic [3:0] cbe_n,
   input wire logic frame_n,
   input wire logic irdy_n,
   input wire logic idsel,
   output logic trdy_n,
   output logic trdy_oe,
   output logic devsel_n,
   output logic devsel_oe,
   output logic stop_n,
   output logic stop_oe,
   input wire logic [4:0] status_set,
   output logic csr_sel,
   output logic csr_we,
   output logic [3:0] csr_index,
   output logic [31:0] csr_wdata,
   output logic [3:0] csr_be_n,
   input wire logic [31:0] csr_rdata,
   output logic io_enable,
   output logic mem_enable,
   output logic master_enable,
   output logic parity_resp,
   output logic serr_enable,
   output logic [7:0] latency_value,
   output logic [7:0] int_line
);

   pcfg_state_type st_q, st_d;
   logic frame_prev_q;
   logic [5:0] cfg_idx_q;
   logic [3:0] csr_idx_q;
   logic cfg_q, csr_q, wr_q;
   logic [31:0] ad_data_q;
   logic csr_sel_q, csr_we_q;
   logic [31:0] csr_wdata_q;
   logic [3:0] csr_be_q;
   logic dec_cfg, dec_io, dec_mem, dec_wr;
   logic addr_phase, cfg_hit, io_hit, mem_hit, claim, done;
   logic cfg_wr_fire;
   logic [31:0] cfg_word, rd_word, cs_set;
   logic [31:0] reg_q [PCFG_NREG];
   logic [31:0] rd_term [PCFG_NREG];
   logic [PCFG_NREG-1:0] reg_hit;

   // ---------------------------------------------------------------
   // command decode of the address phase
   // ---------------------------------------------------------------
   pcfg_cmd_decode u_dec (
      .cmd(cbe_n),
      .is_cfg(dec_cfg),
      .is_io(dec_io),
      .is_mem(dec_mem),
      .is_write(dec_wr)
   );

   // address phase is the first cycle with frame low after it was high
   assign addr_phase = (st_q == PCFG_ST_IDLE) && !frame_n && frame_prev_q;
   // type 0 configuration only; command bits never gate it
   assign cfg_hit = dec_cfg && idsel && (ad_pins[1:0] == 2'b00); // see R18, R15
   assign io_hit = dec_io && io_enable
                   && (ad_pins[31:PCFG_WIN_LSB] == reg_q[PCFG_IDX_IO][31:PCFG_WIN_LSB]); // see R17
   assign mem_hit = dec_mem && mem_enable
                    && (ad_pins[31:PCFG_WIN_LSB] == reg_q[PCFG_IDX_MEM][31:PCFG_WIN_LSB]); // see R17
   assign claim = addr_phase && (cfg_hit || io_hit || mem_hit); // see R06, R04
   // trdy is low all through the data state, so irdy alone closes it
   assign done = (st_q == PCFG_ST_DATA) && !irdy_n; // see R01

   // ---------------------------------------------------------------
   // sequencer: medium devsel, one data phase, then disconnect
   // ---------------------------------------------------------------
   // single-word target keeps the datapath small; bursts are cut by stop
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         PCFG_ST_IDLE: begin
            if (claim) begin
               st_d = PCFG_ST_WAIT;
            end
         end
         PCFG_ST_WAIT: begin
            st_d = PCFG_ST_DATA;
         end
         PCFG_ST_DATA: begin
            if (done) begin
               st_d = frame_n ? PCFG_ST_TURN : PCFG_ST_STOP; // see R01
            end
         end
         PCFG_ST_STOP: begin
            if (frame_n) begin
               st_d = PCFG_ST_TURN;
            end
         end
         PCFG_ST_TURN: begin
            st_d = PCFG_ST_IDLE;
         end
      endcase
   end

   // state and frame history
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= PCFG_ST_IDLE;
         frame_prev_q <= 1'b1;
      end else if (core_ce) begin
         st_q <= st_d;
         frame_prev_q <= frame_n;
      end
   end

   // latch what the address phase told us
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_idx_q <= 6'h00;
         csr_idx_q <= 4'h0;
         cfg_q <= 1'b0;
         csr_q <= 1'b0;
         wr_q <= 1'b0;
      end else if (core_ce && claim) begin
         cfg_idx_q <= ad_pins[7:2];
         csr_idx_q <= ad_pins[PCFG_WIN_LSB-1:PCFG_CSR_LSB]; // see R14
         cfg_q <= cfg_hit;
         csr_q <= !cfg_hit;
         wr_q <= dec_wr;
      end
   end

   // ---------------------------------------------------------------
   // bus pin drive
   // ---------------------------------------------------------------
   // turn state drives the strobes high one cycle before release
   assign devsel_n = !((st_q == PCFG_ST_DATA) || (st_q == PCFG_ST_STOP));
   assign devsel_oe = (st_q == PCFG_ST_DATA) || (st_q == PCFG_ST_STOP)
                      || (st_q == PCFG_ST_TURN);
   assign trdy_n = (st_q != PCFG_ST_DATA); // see R01
   assign trdy_oe = devsel_oe;
   assign stop_n = devsel_n;
   assign stop_oe = devsel_oe;
   assign ad_oe = (st_q == PCFG_ST_DATA) && !wr_q;
   assign ad_data = ad_data_q;

   // ---------------------------------------------------------------
   // configuration register file
   // ---------------------------------------------------------------
   assign cfg_wr_fire = done && cfg_q && wr_q; // see R07
   // status events land on bits 31..28 and 24
   assign cs_set = {status_set[4:1], 3'b000, status_set[0], 24'h00_0000};

   for (genvar i = 0; i < PCFG_NREG; i++) begin : g_reg
      localparam logic [31:0] RV = (i == PCFG_IDX_ID) ? {DEVICE_CODE, MAKER_CODE} :
                                   (i == 2) ? REVISION_VALUE :
                                   (i == 6) ? SUBSYSTEM_VALUE :
                                   (i == PCFG_IDX_CS) ? PCFG_RST_CS :
                                   (i == PCFG_IDX_IO) ? PCFG_RST_IO :
                                   (i == PCFG_IDX_IT) ? PCFG_RST_IT : PCFG_RST_ZERO;
      assign reg_hit[i] = (cfg_idx_q == PCFG_OFS[i][7:2]); // see R12
      // no software reset reaches these; only rst_n loads their reset values
      pcfg_field_reg #(
         .RST_VAL(RV), // see R09, R13
         .WMASK(PCFG_WMASK[i]),
         .CMASK((i == PCFG_IDX_CS) ? PCFG_CMASK_CS : PCFG_RST_ZERO)
      ) u_reg (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .core_ce(core_ce),
         .wr_en(cfg_wr_fire && reg_hit[i]), // see R11
         .be_n(cbe_n),
         .wdata(ad_pins),
         .set_bits((i == PCFG_IDX_CS) ? cs_set : PCFG_RST_ZERO),
         .q(reg_q[i])
      );
      assign rd_term[i] = reg_hit[i] ? reg_q[i] : PCFG_RST_ZERO;
   end

   // gaps and offsets past the last register read as zero
   always_comb begin
      cfg_word = PCFG_RST_ZERO;
      for (int k = 0; k < PCFG_NREG; k++) begin
         cfg_word = cfg_word | rd_term[k]; // see R08
      end
   end
   assign rd_word = cfg_q ? cfg_word : csr_rdata;

   // read data follows the selected word until the phase completes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ad_data_q <= 32'h0000_0000;
      end else if (core_ce && ((st_q == PCFG_ST_WAIT) || (st_q == PCFG_ST_DATA))) begin
         ad_data_q <= rd_word;
      end
   end

   // ---------------------------------------------------------------
   // host register window strobe
   // ---------------------------------------------------------------
   // issued one cycle after completion so the write data is a flop
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         csr_sel_q <= 1'b0;
         csr_we_q <= 1'b0;
         csr_wdata_q <= 32'h0000_0000;
         csr_be_q <= 4'hf;
      end else if (core_ce) begin
         csr_sel_q <= done && csr_q; // see R14
         if (done && csr_q) begin
            csr_we_q <= wr_q;
            csr_wdata_q <= ad_pins;
            csr_be_q <= cbe_n;
         end
      end
   end

   assign csr_sel = csr_sel_q;
   assign csr_we = csr_we_q;
   assign csr_index = csr_idx_q;
   assign csr_wdata = csr_wdata_q;
   assign csr_be_n = csr_be_q;

   // ---------------------------------------------------------------
   // command bits toward the rest of the controller
   // ---------------------------------------------------------------
   assign io_enable = reg_q[PCFG_IDX_CS][PCFG_CMD_BIT_IO];
   assign mem_enable = reg_q[PCFG_IDX_CS][PCFG_CMD_BIT_MEM];
   // the initiator side of memory commands lives outside and obeys this
   assign master_enable = reg_q[PCFG_IDX_CS][PCFG_CMD_BIT_MST]; // see R04
   assign parity_resp = reg_q[PCFG_IDX_CS][PCFG_CMD_BIT_PER];
   assign serr_enable = reg_q[PCFG_IDX_CS][PCFG_CMD_BIT_SERR];
   assign latency_value = reg_q[PCFG_IDX_LT][15:8];
   assign int_line = reg_q[PCFG_IDX_IT][7:0];

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   AST_DATA_BOTH_READY: // see R01
   assert property ($changed(reg_q[PCFG_IDX_DA]) |-> $past(!trdy_n && !irdy_n && core_ce))
      else $error("configuration register written without both ready");

   AST_MEDIUM_CLAIM: // see R05
   assert property (core_ce && claim |=> core_ce [*1] ##0 1 |=> !devsel_n || !core_ce)
      else $error("claimed access did not drive devsel on the second edge");

   AST_NO_UNSUPPORTED: // see R06
   assert property (addr_phase && !dec_cfg && !dec_io && !dec_mem
                    |=> devsel_oe == 1'b0 ##1 devsel_oe == 1'b0)
      else $error("unsupported command was claimed");

   AST_CFG_NEEDS_IDSEL: // see R18
   assert property (addr_phase && dec_cfg && !idsel |=> !devsel_oe ##1 !devsel_oe)
      else $error("configuration claimed without idsel");

   AST_IO_GATED: // see R17
   assert property (addr_phase && (dec_io || dec_mem) && !io_enable && !mem_enable
                    |=> !devsel_oe ##1 !devsel_oe)
      else $error("io or memory claimed while command bits are off");

   AST_RSVD_READ_ZERO: // see R08
   assert property ((st_q == PCFG_ST_DATA) && cfg_q && !wr_q && (reg_hit == '0)
                    && $past(st_q == PCFG_ST_WAIT) |-> ad_data == 32'h0000_0000)
      else $error("reserved configuration read returned nonzero data");

   AST_ID_READ: // see R13
   assert property ((st_q == PCFG_ST_DATA) && cfg_q && (cfg_idx_q == 6'h00)
                    && $past(st_q == PCFG_ST_WAIT) |-> ad_data == {DEVICE_CODE, MAKER_CODE})
      else $error("identity read returned the wrong word");

   AST_RSVD_WRITE_NOP: // see R07
   assert property (cfg_wr_fire && core_ce && (reg_hit == '0) && (status_set == 5'b00000)
                    |=> $stable(reg_q[PCFG_IDX_CS]) && $stable(reg_q[PCFG_IDX_DA]))
      else $error("reserved configuration write changed a register");

   AST_STATUS_W1C: // see R16
   assert property (cfg_wr_fire && core_ce && reg_hit[PCFG_IDX_CS] && !cbe_n[3]
                    && ad_pins[31] && !status_set[4] |=> !reg_q[PCFG_IDX_CS][31])
      else $error("writing one did not clear the parity status bit");

   AST_LANE_MASKED: // see R11
   assert property (cfg_wr_fire && core_ce && reg_hit[PCFG_IDX_DA] && cbe_n[0]
                    |=> reg_q[PCFG_IDX_DA][7:0] == $past(reg_q[PCFG_IDX_DA][7:0]))
      else $error("disabled byte lane was written");

   AST_CSR_STROBE: // see R14
   assert property (core_ce && done && csr_q |=> csr_sel && (csr_we == $past(wr_q)))
      else $error("host register strobe missing after completion");

   COV_CFG_READ: cover property (done && cfg_q && !wr_q);
   COV_CFG_WRITE: cover property (cfg_wr_fire && reg_hit[PCFG_IDX_CS]);
   COV_CSR_ACCESS: cover property (csr_sel && csr_we);
   COV_DISCONNECT: cover property (st_q == PCFG_ST_STOP);

endmodule

// [verification/pcfg_initiator.sv]
// pcfg_initiator: behavioural bus initiator running single-phase transfers.
// assumes the bench resolves the target pins and calls xfer just after an edge.
`timescale 1ns/1ps

module pcfg_initiator (
   input wire logic core_clk,
   input wire logic devsel_w,
   input wire logic trdy_w,
   input wire logic [31:0] ad_in,
   output logic frame_n,
   output logic irdy_n,
   output logic idsel,
   output logic [3:0] cbe_n,
   output logic [31:0] ad_out
);
   // ---------------------------------------------
   // idle levels
   // ---------------------------------------------
   initial begin
      frame_n = 1'b1;
      irdy_n = 1'b1;
      idsel = 1'b0;
      cbe_n = 4'hf;
      ad_out = 32'h0000_0000;
   end

   // ---------------------------------------------
   // address phase, w wait states, one data phase
   // ---------------------------------------------
   // gives up after eight edges, so a target that never claims is aborted
   task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b,
         input logic [31:0] wd, input logic s, input int w,
         output logic [31:0] rd, output logic clm, output int lat);
      logic done;
      rd = 32'h0000_0000;
      clm = 1'b0;
      lat = 0;
      frame_n = 1'b0;
      cbe_n = c;
      ad_out = a;
      idsel = s; // only in the address phase
      @(posedge core_clk);
      #1;
      idsel = 1'b0;
      cbe_n = b;
      ad_out = c[0] ? wd : ~a; // released lines show the inverse of the last value
      for (int n = 1; n <= 8; n++) begin
         if (n > w) begin
            frame_n = 1'b1;
            irdy_n = 1'b0;
         end
         @(posedge core_clk);
         done = !irdy_n && trdy_w === 1'b0; // both ready ends the phase
         if (!clm && devsel_w === 1'b0) begin
            clm = 1'b1;
            lat = n;
         end
         if (done) rd = ad_in; // read data taken only with ready
         #1;
         if (done) break;
      end
      frame_n = 1'b1;
      irdy_n = 1'b1;
      cbe_n = ~cbe_n;
      ad_out = ~ad_out;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
endmodule

// [verification/tb_top.sv]
// tb_top: self-checking bench for the configuration target and host window.
// assumes the package and design files are compiled before it.
`timescale 1ns/1ps

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
   import pcfg_pkg::*;
   // arbitrary identity values
   localparam logic [15:0] DEV = 16'h3c3c;
   localparam logic [15:0] MAK = 16'hc3c3;
   localparam logic [31:0] REV = 32'h0300_0022;
   localparam logic [31:0] SUB = 32'h0000_7777;
   localparam logic [31:0] ID = {DEV, MAK};
   typedef struct {logic [3:0] c; logic [31:0] a; logic [3:0] b; logic [31:0] w;
      logic s; logic k; logic [31:0] e;} pcfg_row_type;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] status_set = 5'h00;
   logic frame_n, irdy_n, idsel, ad_oe, trdy_n, trdy_oe, devsel_n, devsel_oe;
   logic csr_sel, csr_we, cap_we, clm, io_en, mem_en;
   logic [3:0] cbe_n, csr_index, cap_i;
   logic [31:0] ad_out, ad_data, csr_wdata, cap_w, got;
   int lat;
   int error_cnt = 0;
   int compares = 0;
   pcfg_row_type rows[$];
   logic [31:0] rv[PCFG_NREG] = '{ID, 32'h0280_0000, REV, 32'h0000_0000, 32'h0000_0001,
      32'h0000_0000, SUB, 32'h0000_0000, 32'h0000_0100, 32'h0000_0000};
   logic [3:0] bad[10] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hc, 4'hd, 4'he, 4'hf};
   // released pins: pull-ups on the strobes, inverse pattern on the data lines
   wire logic [31:0] ad_pins = ad_oe ? ad_data : ad_out;
   wire logic devsel_w = devsel_oe ? devsel_n : 1'b1;
   wire logic trdy_w = trdy_oe ? trdy_n : 1'b1;
   wire logic [31:0] csr_rdata = {28'hc50_0000, csr_index};

   always #50 core_clk = ~core_clk;

   pcfg_target #(.DEVICE_CODE(DEV), .MAKER_CODE(MAK), .REVISION_VALUE(REV),
      .SUBSYSTEM_VALUE(SUB)) pcfg_target_i (
      .core_clk(core_clk), .rst_n(rst_n), .core_ce(1'b1), .ad_pins(ad_pins),
      .ad_data(ad_data), .ad_oe(ad_oe), .cbe_n(cbe_n), .frame_n(frame_n), .irdy_n(irdy_n),
      .idsel(idsel), .trdy_n(trdy_n), .trdy_oe(trdy_oe), .devsel_n(devsel_n),
      .devsel_oe(devsel_oe), .stop_n(), .stop_oe(), .status_set(status_set),
      .csr_sel(csr_sel), .csr_we(csr_we), .csr_index(csr_index), .csr_wdata(csr_wdata),
      .csr_be_n(), .csr_rdata(csr_rdata), .io_enable(io_en), .mem_enable(mem_en),
      .master_enable(), .parity_resp(), .serr_enable(), .latency_value(), .int_line());

   pcfg_initiator pcfg_initiator_i (.core_clk(core_clk), .devsel_w(devsel_w),
      .trdy_w(trdy_w), .ad_in(ad_pins), .frame_n(frame_n), .irdy_n(irdy_n),
      .idsel(idsel), .cbe_n(cbe_n), .ad_out(ad_out));

   // host register strobe capture, the pulse lasts one cycle only
   always @(posedge core_clk) begin
      if (csr_sel === 1'b1) begin
         cap_i = csr_index;
         cap_w = csr_wdata;
         cap_we = csr_we;
      end
   end

   // ---------------------------------------------
   // row builders and helpers
   // ---------------------------------------------
   function automatic void rd(logic [3:0] c, logic [31:0] a, logic s, logic k, logic [31:0] e);
      rows.push_back('{c, a, 4'h0, 32'h0000_0000, s, k, e});
   endfunction
   function automatic void wr(logic [3:0] c, logic [31:0] a, logic [3:0] b, logic [31:0] w);
      rows.push_back('{c, a, b, w, ~c[3] ? 1'b0 : 1'b1, 1'b1, 32'h0000_0000});
   endfunction
   task automatic go(logic [3:0] c, logic [31:0] a, logic [3:0] b, logic [31:0] w, int wt);
      pcfg_initiator_i.xfer(c, a, b, w, c[3], wt, got, clm, lat);
   endtask
   task automatic print_verdict();
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      for (int j = 0; j < PCFG_NREG; j++) rd(4'ha, 32'(PCFG_OFS[j]), 1'b1, 1'b1, rv[j]);
      for (int o = 'h18; o <= 'h38; o += 4)
         if (o < 'h2c || o > 'h30) rd(4'ha, 32'(o), 1'b1, 1'b1, 32'h0000_0000);
      foreach (bad[j]) rd(bad[j], 32'h0000_0040, 1'b1, 1'b0, 32'h0000_0000);
      rd(4'ha, 32'h0000_0000, 1'b0, 1'b0, 32'h0000_0000);
      rd(4'ha, 32'h0000_0001, 1'b1, 1'b0, 32'h0000_0000);
      wr(4'hb, 32'h0000_0020, 4'h0, 32'hffff_ffff);
      rd(4'ha, 32'h0000_0020, 1'b1, 1'b1, 32'h0000_0000);
      wr(4'hb, 32'h0000_0000, 4'h0, 32'hffff_ffff);
      rd(4'ha, 32'h0000_0000, 1'b1, 1'b1, ID);
      wr(4'hb, 32'h0000_0040, 4'he, 32'haabb_ccdd);
      wr(4'hb, 32'h0000_0040, 4'h3, 32'h1122_3344);
      rd(4'ha, 32'h0000_0040, 1'b1, 1'b1, 32'h1122_00dd);
      rd(4'h2, 32'h0000_0008, 1'b0, 1'b0, 32'h0000_0000);
      wr(4'hb, 32'h0000_0010, 4'h0, 32'h0000_1000);
      wr(4'hb, 32'h0000_0014, 4'h0, 32'h0002_0000);
      wr(4'hb, 32'h0000_0004, 4'h0, 32'h0000_0003);
      rd(4'ha, 32'h0000_0004, 1'b1, 1'b1, 32'h0280_0003);
      rd(4'h2, 32'h0000_1008, 1'b0, 1'b1, 32'hc500_0001);
      wr(4'h3, 32'h0000_1000, 4'h0, 32'h0000_0001);
      rd(4'ha, 32'h0000_0040, 1'b1, 1'b1, 32'h1122_00dd);
      rd(4'ha, 32'h0000_0010, 1'b1, 1'b1, 32'h0000_1001);
      rd(4'h6, 32'h0002_0010, 1'b0, 1'b1, 32'hc500_0002);
      wr(4'h7, 32'h0002_0018, 4'h0, 32'h0000_0005);
      rd(4'h6, 32'h0003_0010, 1'b0, 1'b0, 32'h0000_0000);
      wr(4'hb, 32'h0000_0004, 4'h0, 32'h0000_0000);
      rd(4'h2, 32'h0000_1008, 1'b0, 1'b0, 32'h0000_0000);
      rd(4'h6, 32'h0002_0010, 1'b0, 1'b0, 32'h0000_0000);
      rd(4'ha, 32'h0000_0004, 1'b1, 1'b1, 32'h0280_0000);
      repeat (8) @(posedge core_clk);
      #1 rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      foreach (rows[i]) begin
         pcfg_initiator_i.xfer(rows[i].c, rows[i].a, rows[i].b, rows[i].w, rows[i].s, 0,
            got, clm, lat);
         `CHK(clm, rows[i].k)
         if (rows[i].k) `CHK(lat, 2)
         if (!rows[i].c[0] && rows[i].k) `CHK(got, rows[i].e)
         $display("row %0d done", i);
      end
      // status bit: a pulse sticks, writing zero keeps it, writing one clears it
      @(posedge core_clk);
      #1 status_set = 5'h10;
      @(posedge core_clk);
      #1 status_set = 5'h00;
      go(4'hb, 32'h0000_0004, 4'h0, 32'h0000_0000, 0);
      go(4'ha, 32'h0000_0004, 4'h0, 32'h0000_0000, 0);
      `CHK(got, 32'h8280_0000)
      go(4'hb, 32'h0000_0004, 4'h0, 32'hf100_0000, 0);
      go(4'ha, 32'h0000_0004, 4'h0, 32'h0000_0000, 0);
      `CHK(got, 32'h0280_0000)
      $display("status test done");
      // slow initiator: target must hold ready until the initiator catches up
      go(4'ha, 32'h0000_003c, 4'h0, 32'h0000_0000, 3);
      `CHK(got, 32'h0000_0100)
      `CHK(lat, 2)
      $display("wait state test done");
      // host register write reaches the strobe outputs
      go(4'hb, 32'h0000_0004, 4'h0, 32'h0000_0001, 0);
      `CHK({io_en, mem_en}, 2'b10)
      go(4'h3, 32'h0000_1018, 4'h0, 32'h5a5a_0f0f, 0);
      `CHK(cap_i, 4'h3)
      `CHK(cap_w, 32'h5a5a_0f0f)
      `CHK(cap_we, 1'b1)
      $display("host register test done");
      // hardware reset in mid-run restores the command bits, the io base and the register at 0x40
      rst_n = 1'b0;
      repeat (8) @(posedge core_clk);
      `CHK(devsel_oe, 1'b0)
      `CHK(ad_oe, 1'b0)
      `CHK({io_en, mem_en}, 2'b00)
      #1 rst_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      go(4'ha, 32'h0000_0040, 4'h0, 32'h0000_0000, 0);
      `CHK(got, 32'h0000_0000)
      go(4'ha, 32'h0000_0010, 4'h0, 32'h0000_0000, 0);
      `CHK(got, 32'h0000_0001)
      $display("reset test done");
      print_verdict();
   end

   // hang guard, well beyond the few hundred cycles the run needs
   initial begin
      #(100 * 20000);
      error_cnt++;
      print_verdict();
   end
endmodule
